// file: rtl/nvu_ctrl.sv
// nested vectored interrupt unit: enable, pending, active and priority state,
// arbitration with preemption, vector fetch address, stacking, tail chain, late arrival
// assumes the core executes stack pushes/pops on stk_push_o/stk_pop_o strobes one word
// per cycle, and signals handler end on exc_return_i
//
// Overview of operation
// - 32 request lines with four priority levels
// - preempt only on strictly higher priority
// - level 0 most urgent, 3 least
// - all priority fields reset to zero
// - level 0 below reset, nmi, hard fault
// - vector table base fixed at zero
// - stack pointer at 0x00, entry at number times four
// - push pc, psr, lr, r0-pop later
// - tail chain pending handler without restore
// - late arrival switches vector without delay
// - write one sets or clears enable
// - disabled request pends but never activates
// - disabling leaves active interrupt active
// - write one sets or clears pending
// - pending clear leaves active state alone
// - 8-bit priority fields, four per word
// - fixed line map, exception equals line plus 16
// - only port5, comparator, wake lines wake chip
module nvu_ctrl
    import nvu_pkg::*;
#(
    parameter int LINES = NVU_LINES
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [LINES-1:0] irq_i,
    input wire logic sys_exc_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    input wire logic exc_return_i,
    output logic stk_push_o,
    output logic stk_pop_o,
    output logic [2:0] stk_index_o,
    output logic [5:0] exc_num_o,
    output logic [31:0] vec_addr_o,
    output logic vec_valid_o,
    output logic sp_fetch_addr_valid_o,
    output logic [31:0] sp_fetch_addr_o,
    output logic handler_mode_o,
    output logic wake_o
);
    nvu_state_e state_q;
    nvu_state_e state_d;
    logic [LINES-1:0] enable_q;
    logic [LINES-1:0] pending_q;
    logic [LINES-1:0] active_q;
    logic [LINES-1:0][NVU_PRIO_BITS-1:0] prio_q;
    logic [2:0] stk_cnt_q;
    logic [4:0] sel_line_q;
    logic [4:0] cur_line_q;
    logic [LINES-1:0] cur_stack_q;
    nvu_vec_s vec_q;
    nvu_req_s req;

    assign req = '{write: reg_write_i, read: reg_read_i, addr: reg_addr_i,
                   wdata: reg_wdata_i};

    // field of one line inside an 8-bit slot; decoded for reads and writes
    function automatic logic [31:0] prio_word(input logic [LINES-1:0][1:0] p,
                                              input logic [2:0] w);
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int k = 0; k < 4; k++) begin
            r[k*NVU_PRIO_FIELD + NVU_PRIO_MSB -: NVU_PRIO_BITS] = p[{w, 2'(k)}];
        end
        return r;
    endfunction : prio_word

    // best candidate: lowest level, then lowest line
    logic [LINES-1:0] ready_w;
    logic best_any_w;
    logic [4:0] best_line_w;
    logic [2:0] best_level_w;
    logic [2:0] run_level_w;
    logic [2:0] ret_level_w;
    logic [LINES-1:0] vis_pending_w;
    assign vis_pending_w = pending_q | irq_i;
    assign ready_w = vis_pending_w & enable_q & ~active_q;

    always_comb begin
        best_any_w = 1'b0;
        best_line_w = 5'h00;
        best_level_w = NVU_IDLE_LEVEL;
        for (int i = LINES - 1; i >= 0; i--) begin
            if (ready_w[i] && {1'b0, prio_q[i]} <= best_level_w) begin
                best_any_w = 1'b1;
                best_line_w = 5'(i);
                best_level_w = {1'b0, prio_q[i]};
            end
        end
    end

    // running level is the most urgent active line; idle level sits below level 3
    always_comb begin
        run_level_w = NVU_IDLE_LEVEL;
        ret_level_w = NVU_IDLE_LEVEL;
        for (int i = 0; i < LINES; i++) begin
            if (active_q[i] && {1'b0, prio_q[i]} < run_level_w) begin
                run_level_w = {1'b0, prio_q[i]};
            end
            if (active_q[i] && 5'(i) != cur_line_q && {1'b0, prio_q[i]} < ret_level_w) begin
                ret_level_w = {1'b0, prio_q[i]};
            end
        end
    end

    // system exceptions (reset, nmi, hard fault) are outside this unit and block it
    logic take_w;
    logic late_w;
    logic stack_done_w;
    logic unstack_done_w;
    logic chain_w;
    assign take_w = best_any_w && !sys_exc_i && best_level_w < run_level_w;
    assign late_w = state_q == NVU_ST_STACK && best_any_w && !sys_exc_i &&
                    best_level_w < {1'b0, prio_q[sel_line_q]};
    assign stack_done_w = state_q == NVU_ST_STACK && stk_cnt_q == 3'(NVU_STACK_WORDS - 1);
    assign unstack_done_w = state_q == NVU_ST_UNSTACK &&
                            stk_cnt_q == 3'(NVU_STACK_WORDS - 1);
    // the finishing handler no longer counts, so an equal-level line still chains
    assign chain_w = state_q == NVU_ST_HANDLER && exc_return_i && best_any_w && !sys_exc_i &&
                     best_level_w < ret_level_w;

    always_comb begin
        state_d = state_q;
        case (state_q)
            NVU_ST_RUN: begin
                if (take_w) begin
                    state_d = NVU_ST_STACK;
                end
            end
            NVU_ST_STACK: begin
                if (stack_done_w) begin
                    state_d = NVU_ST_HANDLER;
                end
            end
            NVU_ST_HANDLER: begin
                if (exc_return_i && !chain_w) begin
                    state_d = NVU_ST_UNSTACK;
                end else if (take_w && !exc_return_i) begin
                    state_d = NVU_ST_STACK;
                end
            end
            NVU_ST_UNSTACK: begin
                if (unstack_done_w) begin
                    state_d = NVU_ST_HANDLER;
                    if (cur_stack_q == '0 || cur_stack_q == (LINES'(1) << cur_line_q)) begin
                        state_d = NVU_ST_RUN;
                    end
                end
            end
            default: state_d = NVU_ST_RUN;
        endcase
    end

    // register writes
    logic wr_en_set_w;
    logic wr_en_clr_w;
    logic wr_pd_set_w;
    logic wr_pd_clr_w;
    logic wr_prio_w;
    logic [2:0] prio_idx_w;
    assign wr_en_set_w = req.write && req.addr == NVU_ENABLE_SET_OFS;
    assign wr_en_clr_w = req.write && req.addr == NVU_ENABLE_CLEAR_OFS;
    assign wr_pd_set_w = req.write && req.addr == NVU_PENDING_SET_OFS;
    assign wr_pd_clr_w = req.write && req.addr == NVU_PENDING_CLEAR_OFS;
    assign wr_prio_w = req.write && req.addr >= NVU_PRIO_OFS && req.addr <= NVU_PRIO_LAST_OFS &&
                       req.addr[1:0] == 2'h0;
    assign prio_idx_w = req.addr[4:2];

    // entry of a line: take it and its pending bit goes away
    logic entry_w;
    logic [4:0] entry_line_w;
    logic [LINES-1:0] entry_mask_w;
    logic ret_w;
    assign entry_w = stack_done_w || chain_w;
    assign entry_line_w = chain_w ? best_line_w : (late_w ? best_line_w : sel_line_q);
    assign entry_mask_w = entry_w ? (LINES'(1) << entry_line_w) : '0;
    assign ret_w = state_q == NVU_ST_HANDLER && exc_return_i;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            enable_q <= '0;
        end else begin
            enable_q <= (enable_q | (wr_en_set_w ? req.wdata : '0)) &
                        ~(wr_en_clr_w ? req.wdata : '0);
        end
    end

    // hardware set from the line wins over a software clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pending_q <= '0;
        end else begin
            pending_q <= (((pending_q & ~(wr_pd_clr_w ? req.wdata : '0))
                          | (wr_pd_set_w ? req.wdata : '0)) & ~entry_mask_w)
                         | (irq_i & ~entry_mask_w);
        end
    end

    // active only drops on exception return; enable and pending clears leave it
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            active_q <= '0;
        end else begin
            active_q <= (active_q & ~(ret_w ? (LINES'(1) << cur_line_q) : '0))
                        | entry_mask_w;
        end
    end

    for (genvar g = 0; g < LINES; g++) begin : g_prio
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                prio_q[g] <= NVU_PRIO_RESET;
            end else if (wr_prio_w && prio_idx_w == 3'(g / 4)) begin
                prio_q[g] <= req.wdata[(g%4)*NVU_PRIO_FIELD + NVU_PRIO_MSB -: NVU_PRIO_BITS];
            end
        end
    end

    // current line tracks the most urgent still-active line after a return
    logic [4:0] next_cur_w;
    logic next_found_w;
    logic [LINES-1:0] after_ret_w;
    assign after_ret_w = active_q & ~(LINES'(1) << cur_line_q);
    // first survivor is taken outright: it is always less urgent than the returned line
    always_comb begin
        next_cur_w = cur_line_q;
        next_found_w = 1'b0;
        for (int i = LINES - 1; i >= 0; i--) begin
            if (after_ret_w[i] && (!next_found_w || prio_q[i] <= prio_q[next_cur_w])) begin
                next_cur_w = 5'(i);
                next_found_w = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_q <= NVU_ST_RUN;
            stk_cnt_q <= 3'h0;
            sel_line_q <= 5'h00;
            cur_line_q <= 5'h00;
            cur_stack_q <= '0;
        end else begin
            state_q <= state_d;
            stk_cnt_q <= (state_d != state_q || chain_w) ? 3'h0 : stk_cnt_q + 3'h1;
            if (take_w && state_q != NVU_ST_STACK || late_w) begin
                sel_line_q <= best_line_w;
            end
            if (entry_w) begin
                cur_line_q <= entry_line_w;
            end else if (unstack_done_w) begin
                cur_line_q <= next_cur_w;
            end
            cur_stack_q <= active_q;
        end
    end

    // vector address: base plus exception number times stride
    logic [5:0] exc_w;
    assign exc_w = 6'(entry_line_w) + 6'(NVU_EXC_OFFSET);
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            vec_q <= '0;
        end else begin
            vec_q.valid <= entry_w;
            vec_q.exc_num <= exc_w;
            vec_q.vec_addr <= NVU_VTOR_BASE + 32'(exc_w) * NVU_ENTRY_STRIDE;
        end
    end

    assign vec_valid_o = vec_q.valid;
    assign exc_num_o = vec_q.exc_num;
    assign vec_addr_o = vec_q.vec_addr;
    assign sp_fetch_addr_o = NVU_VTOR_BASE + NVU_SP_ENTRY;
    assign sp_fetch_addr_valid_o = 1'b0;
    assign stk_push_o = state_q == NVU_ST_STACK;
    assign stk_pop_o = state_q == NVU_ST_UNSTACK;
    assign stk_index_o = stk_cnt_q;
    assign handler_mode_o = state_q == NVU_ST_HANDLER;
    assign wake_o = |(vis_pending_w & enable_q & NVU_WAKE_MASK[LINES-1:0]);

    // reads: enable and pending pairs both show current state
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (req.read) begin
            reg_rdata_o <= 32'h0000_0000;
            if (req.addr == NVU_ENABLE_SET_OFS || req.addr == NVU_ENABLE_CLEAR_OFS) begin
                reg_rdata_o <= 32'(enable_q);
            end else if (req.addr == NVU_PENDING_SET_OFS || req.addr == NVU_PENDING_CLEAR_OFS) begin
                reg_rdata_o <= 32'(pending_q);
            end else if (req.addr >= NVU_PRIO_OFS && req.addr <= NVU_PRIO_LAST_OFS) begin
                reg_rdata_o <= prio_word(prio_q, req.addr[4:2]);
            end
        end
    end

    // assertions
    chk_prio_reset: assert property (@(posedge clk_i) $fell(reset_i) |-> prio_q == '0)
        else $error("priority not zero after reset");
    chk_reset_idle: assert property (@(posedge clk_i) $fell(reset_i) |-> active_q == '0)
        else $error("active state survived reset");
    chk_en_set: assert property (@(posedge clk_i) disable iff (reset_i)
        wr_en_set_w && !wr_en_clr_w |=> (enable_q & $past(req.wdata)) == $past(req.wdata))
        else $error("enable set lost");
    chk_disabled_idle: assert property (@(posedge clk_i) disable iff (reset_i)
        entry_w |-> enable_q[entry_line_w])
        else $error("disabled line activated");
    chk_active_kept: assert property (@(posedge clk_i) disable iff (reset_i)
        active_q[cur_line_q] && !ret_w |=> active_q[$past(cur_line_q)])
        else $error("active line dropped without return");
    chk_pend_cleared: assert property (@(posedge clk_i) disable iff (reset_i)
        entry_w && !irq_i[entry_line_w] |=> !pending_q[$past(entry_line_w)])
        else $error("pending stays after entry");
    sequence s_stacking;
        stk_push_o [*8];
    endsequence
    chk_stack_len: assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(stk_push_o) && !late_w |-> s_stacking ##1 handler_mode_o)
        else $error("stacking not eight words");
    chk_vec_addr: assert property (@(posedge clk_i) disable iff (reset_i)
        vec_valid_o |-> vec_addr_o == {24'h0, exc_num_o, 2'h0})
        else $error("vector address wrong");
    chk_preempt_level: assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(stk_push_o) |-> {1'b0, prio_q[sel_line_q]} < run_level_w)
        else $error("preempt without higher priority");
    chk_tail_chain: assert property (@(posedge clk_i) disable iff (reset_i)
        chain_w |=> handler_mode_o && !stk_pop_o)
        else $error("tail chain restored state");
    chk_chain_vector: assert property (@(posedge clk_i) disable iff (reset_i)
        chain_w |=> vec_valid_o && !stk_push_o)
        else $error("tail chain gave no vector");
endmodule : nvu_ctrl

// file: rtl/nvu_pkg.sv
// package for the nested vectored interrupt unit: register map, field layout, timing
// assumes a single 100 MHz clock and a core that consumes vector and stacking requests
package nvu_pkg;
    localparam int NVU_LINES = 32;
    localparam int NVU_PRIO_BITS = 2;
    localparam int NVU_PRIO_FIELD = 8;
    localparam int NVU_PRIO_MSB = 7;
    localparam int NVU_PRIO_REGS = 8;
    localparam int NVU_EXC_OFFSET = 16;
    localparam int NVU_STACK_WORDS = 8;
    localparam logic [31:0] NVU_VTOR_BASE = 32'h0000_0000;
    localparam logic [31:0] NVU_SP_ENTRY = 32'h0000_0000;
    localparam logic [31:0] NVU_ENTRY_STRIDE = 32'h0000_0004;
    localparam logic [1:0] NVU_PRIO_RESET = 2'h0;
    localparam logic [2:0] NVU_IDLE_LEVEL = 3'h4;
    // register offsets in the system control space
    localparam logic [11:0] NVU_ENABLE_SET_OFS = 12'h100;
    localparam logic [11:0] NVU_ENABLE_CLEAR_OFS = 12'h180;
    localparam logic [11:0] NVU_PENDING_SET_OFS = 12'h200;
    localparam logic [11:0] NVU_PENDING_CLEAR_OFS = 12'h280;
    localparam logic [11:0] NVU_PRIO_OFS = 12'h400;
    localparam logic [11:0] NVU_PRIO_LAST_OFS = 12'h41C;
    // line assignments
    localparam int NVU_SPI_LINE = 14;
    localparam int NVU_PORT5_LINE = 16;
    localparam int NVU_TRIM_LINE = 17;
    localparam int NVU_TWI_LINE = 18;
    localparam int NVU_CMP_LINE = 25;
    localparam int NVU_WAKE_LINE = 28;
    localparam int NVU_ADC_LINE = 29;
    localparam logic [31:0] NVU_WAKE_MASK = 32'h1201_0000;
    typedef enum {
        NVU_ST_RUN,
        NVU_ST_STACK,
        NVU_ST_HANDLER,
        NVU_ST_UNSTACK
    } nvu_state_e;
    typedef struct packed {
        logic        write;
        logic        read;
        logic [11:0] addr;
        logic [31:0] wdata;
    } nvu_req_s;
    typedef struct packed {
        logic        valid;
        logic [5:0]  exc_num;
        logic [31:0] vec_addr;
    } nvu_vec_s;
endpackage : nvu_pkg

// file: bench/nvu_core_model.sv
// core stand-in: times each handler and pulses handler end
// assumes vec_valid_i marks an entry and stk_pop_i marks unstacking
module nvu_core_model (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic vec_valid_i,
    input wire logic stk_pop_i,
    input wire logic [7:0] ret_delay_i,
    output logic exc_return_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int depth;
    int cnt;
    // a preempted handler resumes only after pops end, so its timer restarts then
    initial begin
        exc_return_o = 1'b0;
        depth = 0;
        cnt = -1;
        forever begin
            @(negedge clk_i);
            exc_return_o = 1'b0;
            if (reset_i) begin
                depth = 0;
                cnt = -1;
            end else if (vec_valid_i) begin
                depth++;
                cnt = int'(ret_delay_i);
            end else if (cnt == 0) begin
                exc_return_o = 1'b1;
                depth--;
                cnt = -1;
            end else if (cnt > 0) begin
                cnt--;
            end else if (depth > 0 && !stk_pop_i) begin
                cnt = int'(ret_delay_i);
            end
        end
    end
endmodule : nvu_core_model

// file: bench/nested_vectored_irq_controller_test.sv
// self-checking bench for the interrupt unit with a core stand-in
// assumes register offsets and entry timing from the shared package
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin bad_count++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module nested_vectored_irq_controller_test import nvu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset, sys_exc, reg_write, reg_read, exc_ret;
    logic push, pop, vval, handler, wake, sp_valid;
    logic [31:0] irq, reg_wdata, reg_rdata, vaddr, sp_addr;
    logic [11:0] reg_addr;
    logic [2:0] idx;
    logic [5:0] exc_num;
    logic [7:0] ret_delay;
    int bad_count, checks_done, push_n, pop_n, vec_n, idx_n;
    nvu_ctrl nvu_ctrl_i (.clk_i(clk), .reset_i(reset), .irq_i(irq), .sys_exc_i(sys_exc),
        .reg_write_i(reg_write), .reg_read_i(reg_read), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .exc_return_i(exc_ret),
        .stk_push_o(push), .stk_pop_o(pop), .stk_index_o(idx), .exc_num_o(exc_num),
        .vec_addr_o(vaddr), .vec_valid_o(vval), .sp_fetch_addr_valid_o(sp_valid),
        .sp_fetch_addr_o(sp_addr), .handler_mode_o(handler), .wake_o(wake));
    nvu_core_model nvu_core_model_i (.clk_i(clk), .reset_i(reset), .vec_valid_i(vval),
        .stk_pop_i(pop), .ret_delay_i(ret_delay), .exc_return_o(exc_ret));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // counted just after the edge so values are settled
    always @(posedge clk) begin
        #2;
        push_n += int'(push === 1'b1);
        idx_n += (push === 1'b1) ? int'(idx) : 0;
        pop_n += int'(pop === 1'b1);
        vec_n += int'(vval === 1'b1);
    end
    task automatic conclude();
        if (bad_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge clk);
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_write = 1'b0;
    endtask : reg_wr
    task automatic reg_chk(input logic [11:0] a, input logic [31:0] ex, input string nm);
        @(negedge clk);
        reg_read = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_read = 1'b0;
        `CHK(nm, ex, reg_rdata);
    endtask : reg_chk
    task automatic pulse(input int n);
        @(negedge clk);
        irq[n] = 1'b1;
        @(negedge clk);
        irq[n] = 1'b0;
    endtask : pulse
    task automatic wait_vec(input logic [5:0] ex, input int lim);
        repeat (lim) if (vval !== 1'b1) @(negedge clk);
        `CHK("vector taken", 1'b1, vval);
        `CHK("exception number", ex, exc_num);
        `CHK("vector address", NVU_VTOR_BASE + {24'h00_0000, ex, 2'h0}, vaddr);
        @(negedge clk);
    endtask : wait_vec
    task automatic wait_idle();
        repeat (300) if (handler !== 1'b0 || pop !== 1'b0) @(negedge clk);
        `CHK("idle", 1'b0, handler);
    endtask : wait_idle
    task automatic t_reset();
        for (int i = 0; i < 8; i++) reg_chk(NVU_PRIO_OFS + 12'(4 * i), 32'h0, "prio");
        reg_chk(NVU_ENABLE_SET_OFS, 32'h0, "enable at reset");
        reg_chk(NVU_PENDING_SET_OFS, 32'h0, "pending at reset");
    endtask : t_reset
    task automatic t_regs();
        reg_wr(NVU_ENABLE_SET_OFS, 32'hA5A5_0000);
        reg_wr(NVU_ENABLE_SET_OFS, 32'h0000_0000);
        reg_chk(NVU_ENABLE_CLEAR_OFS, 32'hA5A5_0000, "enable via clear");
        reg_wr(NVU_ENABLE_CLEAR_OFS, 32'h0005_0000);
        reg_chk(NVU_ENABLE_SET_OFS, 32'hA5A0_0000, "enable after clear");
        reg_wr(NVU_ENABLE_CLEAR_OFS, 32'hFFFF_FFFF);
        reg_wr(NVU_PRIO_LAST_OFS, 32'hFFFF_FFFF);
        reg_chk(NVU_PRIO_LAST_OFS, 32'hC0C0_C0C0, "prio fields");
        reg_wr(NVU_PRIO_LAST_OFS, 32'h0000_0000);
        reg_wr(12'h300, 32'hFFFF_FFFF);
        reg_chk(12'h300, 32'h0, "unmapped");
        reg_chk(12'h102, 32'h0, "unaligned");
    endtask : t_regs
    task automatic t_disabled();
        pulse(3);
        reg_chk(NVU_PENDING_SET_OFS, 32'h0000_0008, "pend disabled");
        reg_chk(NVU_PENDING_CLEAR_OFS, 32'h0000_0008, "pend via clear");
        repeat (20) @(negedge clk);
        `CHK("no entry disabled", 1'b0, handler);
        reg_wr(NVU_PENDING_CLEAR_OFS, 32'h0000_0008);
        reg_wr(NVU_PENDING_SET_OFS, 32'h0000_0010);
        reg_chk(NVU_PENDING_CLEAR_OFS, 32'h0000_0010, "pend set");
        reg_wr(NVU_PENDING_CLEAR_OFS, 32'h0000_0010);
        reg_chk(NVU_PENDING_SET_OFS, 32'h0, "pend cleared");
    endtask : t_disabled
    task automatic t_entry();
        ret_delay = 8'h3C;
        reg_wr(NVU_ENABLE_SET_OFS, 32'h0000_4000);
        push_n = 0;
        idx_n = 0;
        pulse(NVU_SPI_LINE);
        wait_vec(6'h1E, 20);
        `CHK("pushes", 8, push_n);
        `CHK("stack entry", 32'h0, sp_addr);
        `CHK("stack entry fetch", 1'b0, sp_valid);
        `CHK("stack index sum", 28, idx_n);
        reg_chk(NVU_PENDING_SET_OFS, 32'h0, "pend on entry");
        reg_wr(NVU_ENABLE_CLEAR_OFS, 32'h0000_4000);
        reg_wr(NVU_PENDING_CLEAR_OFS, 32'h0000_4000);
        `CHK("still active", 1'b1, handler);
        pop_n = 0;
        wait_idle();
        `CHK("pops", 8, pop_n);
    endtask : t_entry
    task automatic t_preempt();
        int v0;
        reg_wr(NVU_PRIO_OFS + 12'h010, 32'h0040_8080);
        reg_wr(NVU_ENABLE_SET_OFS, 32'h0007_0000);
        pulse(NVU_PORT5_LINE);
        wait_vec(6'h20, 20);
        v0 = vec_n;
        pulse(NVU_TRIM_LINE);
        repeat (20) @(negedge clk);
        `CHK("equal level waits", v0, vec_n);
        pulse(NVU_TWI_LINE);
        wait_vec(6'h22, 20);
        wait_vec(6'h21, 250);
        wait_idle();
        reg_wr(NVU_ENABLE_CLEAR_OFS, 32'hFFFF_FFFF);
    endtask : t_preempt
    task automatic t_chain();
        ret_delay = 8'h1E;
        sys_exc = 1'b1;
        reg_wr(NVU_ENABLE_SET_OFS, 32'h3000_0000);
        reg_wr(NVU_PENDING_SET_OFS, 32'h2000_0000);
        `CHK("no wake", 1'b0, wake);
        reg_wr(NVU_PENDING_SET_OFS, 32'h1000_0000);
        `CHK("wake", 1'b1, wake);
        repeat (20) @(negedge clk);
        `CHK("held by system", 1'b0, handler);
        sys_exc = 1'b0;
        wait_vec(6'h2C, 20);
        pop_n = 0;
        wait_vec(6'h2D, 60);
        `CHK("chain pops", 0, pop_n);
        wait_idle();
    endtask : t_chain
    task automatic t_late();
        ret_delay = 8'h28;
        reg_wr(NVU_PRIO_OFS + 12'h00C, 32'h0040_0000);
        reg_wr(NVU_PRIO_OFS + 12'h010, 32'h0000_0000);
        reg_wr(NVU_ENABLE_SET_OFS, 32'h0004_4000);
        push_n = 0;
        pulse(NVU_SPI_LINE);
        pulse(NVU_TWI_LINE);
        wait_vec(6'h22, 8);
        `CHK("late pushes", 8, push_n);
        pop_n = 0;
        wait_vec(6'h1E, 60);
        `CHK("late chain pops", 0, pop_n);
        wait_idle();
    endtask : t_late
    task automatic t_midreset();
        reg_wr(NVU_ENABLE_SET_OFS, 32'h0000_4000);
        pulse(NVU_SPI_LINE);
        wait_vec(6'h1E, 20);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        `CHK("handler after reset", 1'b0, handler);
        t_reset();
    endtask : t_midreset
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        conclude();
    end
    initial begin
        {reset, sys_exc, reg_write, reg_read} = 4'h8;
        {irq, reg_wdata, reg_addr, ret_delay} = '0;
        {bad_count, checks_done, push_n, pop_n, vec_n, idx_n} = '0;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        t_reset();
        t_regs();
        t_disabled();
        t_entry();
        t_preempt();
        t_chain();
        t_late();
        t_midreset();
        conclude();
    end
endmodule : nested_vectored_irq_controller_test
